// ---- sim/tcf_timer_properties.sv ----
// port assertions of the timer compare block
`timescale 1ns/1ns
`include "tcf_map.vh"
module tcf_timer_properties (
   input logic       clk,
   input logic       arst_n,
   input logic [7:0] regAddr,
   input logic [7:0] regWdata,
   input logic       regWr,
   input logic       regRd,
   input logic [7:0] regRdata,
   input logic       vecAck,
   input logic [3:0] vecNum,
   input logic       cmpAPinN,
   input logic       cmpBPin,
   input logic       cmpBPinOe,
   input logic       cmpBPinN,
   input logic       irqCmpA,
   input logic       irqCmpB,
   input logic       irqOvf
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_inv_a_off: assert property (!cmpAPinN) else $error("inverted A driven");
   a_inv_b_off: assert property (!cmpBPinN) else $error("inverted B driven");
   a_vec_a_clr: assert property (vecAck && vecNum == `TCF_VEC_CMPA |-> ##[1:4] !irqCmpA) else $error("A kept");
   a_vec_b_clr: assert property (vecAck && vecNum == `TCF_VEC_CMPB |-> ##[1:4] !irqCmpB) else $error("B kept");
   a_vec_ovf_clr: assert property (vecAck && vecNum == `TCF_VEC_OVF |-> ##[1:4] !irqOvf) else $error("ovf kept");
   a_gtc_rd_zero: assert property ($past(regRd) && $past(regAddr) == `TCF_OFS_GTC
      |-> regRdata[3:1] == 3'h0) else $error("gtc read");
   a_flag_rsvd: assert property ($past(regRd) && $past(regAddr) == `TCF_OFS_TFLAG
      |-> (regRdata & 8'h9b) == 8'h00) else $error("flag read");
   a_mask_rsvd: assert property ($past(regRd) && $past(regAddr) == `TCF_OFS_TMASK
      |-> (regRdata & 8'h9b) == 8'h00) else $error("mask read");
   a_force_b_set: assert property (regWr && regAddr == `TCF_OFS_GTC && regWdata[6:3] == 4'h7
      |-> ##[1:3] cmpBPin && cmpBPinOe) else $error("force B");
   a_mode_b_off: assert property (regWr && regAddr == `TCF_OFS_GTC && regWdata[6:4] == 3'h0
      |-> ##[1:3] !cmpBPinOe) else $error("B not off");
endmodule
bind tcf_timer tcf_timer_properties i_props (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
   .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .vecAck(vecAck), .vecNum(vecNum), .cmpAPinN(cmpAPinN),
   .cmpBPin(cmpBPin), .cmpBPinOe(cmpBPinOe), .cmpBPinN(cmpBPinN), .irqCmpA(irqCmpA), .irqCmpB(irqCmpB),
   .irqOvf(irqOvf));

// ---- sim/tcf_timer_tb_top.sv ----
// self-checking bench of the timer compare block
`timescale 1ns/1ns
`include "tcf_map.vh"
module tcf_timer_tb_top;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic        vecAck = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [7:0]  regWdata = 8'h00;
   logic [7:0]  v;
   logic [3:0]  vecNum = 4'h0;
   wire  [7:0]  regRdata;
   wire         aP, aOe, aN, bP, bOe, bN, iA, iB, iO;
   int          n_errors = 0;
   int          checked = 0;
   // rows: address, reset value, write value, read-back value
   logic [31:0] rows [8] = '{{`TCF_OFS_CMPA, 24'h005a5a}, {`TCF_OFS_CMPB, 24'h00a5a5}, {`TCF_OFS_CMPC, 24'hff3c3c},
      {`TCF_OFS_TMASK, 24'h00ff64}, {`TCF_OFS_GTC, 24'h00fef0}, {`TCF_OFS_TFLAG, 24'h00ff00}, {8'h10, 24'h00ff00},
      {`TCF_OFS_TCTRL, 24'h000000}};
   logic [7:0]  frc [4] = '{8'h18, 8'h28, 8'h38, 8'h18};
   always #50 clk = ~clk;
   tcf_timer i_dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .vecAck(vecAck), .vecNum(vecNum), .cmpAPin(aP), .cmpAPinOe(aOe),
      .cmpAPinN(aN), .cmpBPin(bP), .cmpBPinOe(bOe), .cmpBPinN(bN), .irqCmpA(iA), .irqCmpB(iB), .irqOvf(iO));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 v = regRdata;
   endtask
   task automatic vec(input logic [3:0] n);
      @(posedge clk);
      vecAck <= 1'b1;
      vecNum <= n;
      @(posedge clk);
      vecAck <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // generous bound: the whole sequence needs well under a thousand cycles
   initial begin
      #2000000;
      n_errors++;
      end_sim();
   end
   initial begin
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      foreach (rows[i]) begin
         rd(rows[i][31:24]);
         chk(v, rows[i][23:16]);
         wr(rows[i][31:24], rows[i][15:8]);
         rd(rows[i][31:24]);
         chk(v, rows[i][7:0]);
      end
      $display("test regs done");
      foreach (frc[i]) begin
         wr(`TCF_OFS_GTC, frc[i]);
         tk(3);
         chk({7'h0, bP}, {7'h0, ~i[0]});
      end
      wr(`TCF_OFS_GTC, 8'h78);
      tk(3);
      chk({7'h0, bP}, 8'h00);
      wr(`TCF_OFS_GTC, 8'h08);
      tk(3);
      chk({6'h0, bOe, bN}, 8'h00);
      wr(`TCF_OFS_TCTRL, 8'h30);
      wr(`TCF_OFS_GTC, 8'h04);
      tk(3);
      chk({5'h0, aP, aOe, aN}, 8'h06);
      wr(`TCF_OFS_TCTRL, 8'h60);
      wr(`TCF_OFS_GTC, 8'h04);
      tk(3);
      chk({7'h0, aP}, 8'h01);
      rd(`TCF_OFS_TFLAG);
      chk(v, 8'h00);
      $display("test force done");
      wr(`TCF_OFS_TCTRL, 8'h00);
      wr(`TCF_OFS_CMPA, 8'h10);
      wr(`TCF_OFS_CMPB, 8'h20);
      wr(`TCF_OFS_CNT, 8'h10);
      tk(3);
      rd(`TCF_OFS_CNT);
      chk(v, 8'h10);
      wr(`TCF_OFS_TCTRL, 8'h01);
      tk(8);
      rd(`TCF_OFS_TFLAG);
      chk(v, 8'h00);
      tk(20);
      rd(`TCF_OFS_TFLAG);
      chk(v, 8'h20);
      chk({7'h0, iB}, 8'h01);
      vec(`TCF_VEC_CMPB);
      chk({7'h0, iB}, 8'h00);
      wr(`TCF_OFS_TCTRL, 8'h00);
      wr(`TCF_OFS_TFLAG, 8'h64);
      wr(`TCF_OFS_CNT, 8'hfc);
      wr(`TCF_OFS_CMPA, 8'h01);
      wr(`TCF_OFS_CMPB, 8'h80);
      wr(`TCF_OFS_TCTRL, 8'h01);
      tk(12);
      rd(`TCF_OFS_TFLAG);
      chk(v, 8'h44);
      chk({6'h0, iA, iO}, 8'h03);
      wr(`TCF_OFS_TFLAG, 8'h00);
      rd(`TCF_OFS_TFLAG);
      chk(v, 8'h44);
      vec(`TCF_VEC_CMPA);
      chk({7'h0, iA}, 8'h00);
      wr(`TCF_OFS_TFLAG, 8'h04);
      tk(2);
      rd(`TCF_OFS_TFLAG);
      chk(v, 8'h00);
      $display("test flags done");
      wr(`TCF_OFS_TCTRL, 8'h00);
      wr(`TCF_OFS_CNT, 8'h00);
      wr(`TCF_OFS_CMPC, 8'h08);
      wr(`TCF_OFS_TCTRL, 8'h81);
      tk(3);
      wr(`TCF_OFS_TFLAG, 8'h64);
      tk(40);
      rd(`TCF_OFS_CNT);
      chk({7'h0, v <= 8'h08}, 8'h01);
      rd(`TCF_OFS_TFLAG);
      chk(v & 8'h04, 8'h00);
      wr(`TCF_OFS_TCTRL, 8'h01);
      wr(`TCF_OFS_GTC, 8'h40);
      wr(`TCF_OFS_TFLAG, 8'h64);
      tk(30);
      rd(`TCF_OFS_CNT);
      chk({7'h0, v <= 8'h08}, 8'h01);
      rd(`TCF_OFS_TFLAG);
      chk(v & 8'h04, 8'h04);
      wr(`TCF_OFS_TCTRL, 8'h00);
      tk(6);
      vec(`TCF_VEC_OVF);
      chk({7'h0, iO}, 8'h00);
      $display("test counter done");
      // mid-run reset: outputs drop at once, compare C returns to its top value
      arst_n <= 1'b0;
      tk(2);
      chk({aP, aOe, bP, bOe, iA, iB, iO, regRdata[0]}, 8'h00);
      arst_n <= 1'b1;
      rd(`TCF_OFS_CMPC);
      chk(v, `TCF_CNT_TOP);
      rd(`TCF_OFS_TFLAG);
      chk(v, 8'h00);
      $display("test reset done");
      end_sim();
   end
endmodule

// ---- src/tcf_map.vh ----
// register offsets, field positions and timing counts of the timer compare block
`ifndef TCF_MAP_VH
`define TCF_MAP_VH
`define TCF_ADDR_W        8
`define TCF_OFS_GTC       8'h2c
`define TCF_OFS_TFLAG     8'h38
`define TCF_OFS_TCTRL     8'h30
`define TCF_OFS_CNT       8'h2f
`define TCF_OFS_CMPA      8'h2e
`define TCF_OFS_CMPB      8'h2b
`define TCF_OFS_CMPC      8'h2d
`define TCF_OFS_TMASK     8'h39
// general_timer_control fields
`define TCF_GTC_PWMB      6
`define TCF_GTC_MODEB_HI  5
`define TCF_GTC_MODEB_LO  4
`define TCF_GTC_FORCEB    3
`define TCF_GTC_FORCEA    2
`define TCF_GTC_PSR       1
// timer_control fields
`define TCF_TC_CLRCMP     7
`define TCF_TC_PWMA       6
`define TCF_TC_MODEA_HI   5
`define TCF_TC_MODEA_LO   4
// mask / flag fields
`define TCF_BIT_CMPA      6
`define TCF_BIT_CMPB      5
`define TCF_BIT_OVF       2
`define TCF_IRQ_MASK      8'h64
// interrupt vectors
`define TCF_VEC_CMPA      4'h3
`define TCF_VEC_OVF       4'h4
`define TCF_VEC_CMPB      4'h9
`define TCF_RST_BYTE      8'h00
`define TCF_CNT_TOP       8'hff
// flag set delay after the compare event, in cycles
`define TCF_FLAG_SYNC     2
`endif

// ---- src/tcf_out_unit.v ----
// one compare output channel: pin action on match or force
`timescale 1ns/1ns
module tcf_out_unit (
   input  wire         clk,
   input  wire         arst_n,
   input  wire         fire,
   input  wire [1:0]   mode,
   output reg          pin,
   output reg          pinOe
);
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin   <= 1'b0;
         pinOe <= 1'b0;
      end else begin
         pinOe <= (mode != 2'b00);
         if (fire) begin
            case (mode)
               2'b01:   pin <= ~pin;
               2'b10:   pin <= 1'b0;
               2'b11:   pin <= 1'b1;
               default: pin <= pin;
            endcase
         end
      end
   end
endmodule

// ---- src/tcf_prescaler.v ----
// prescaler that divides the clock into a count-enable pulse
`timescale 1ns/1ns
`include "tcf_map.vh"
module tcf_prescaler #(
   parameter W = 14
) (
   input  wire         clk,
   input  wire         arst_n,
   input  wire         clear,
   input  wire [3:0]   sel,
   output reg          tick
);
   reg  [W-1:0] div_r;
   wire [W-1:0] divNxt = div_r + {{(W-1){1'b0}}, 1'b1};
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_r <= {W{1'b0}};
         tick  <= 1'b0;
      end else if (clear) begin
         div_r <= {W{1'b0}};
         tick  <= 1'b0;
      end else begin
         div_r <= divNxt;
         // sel 1 = every cycle, sel n = every 2^(n-1)
         if (sel == 4'h0)
            tick <= 1'b0;
         else if (sel == 4'h1)
            tick <= 1'b1;
         else
            tick <= (div_r[sel-4'h2 +: 1] == 1'b1) && (divNxt[sel-4'h2 +: 1] == 1'b0);
      end
   end
endmodule

// ---- src/tcf_timer.v ----
// 8-bit timer with three compares, force outputs, prescaler reset and flags
// Operation
// R1: channel B PWM restarts counter after C
// R2: output mode 00 off, toggle, low, high
// R3: software sets pin direction before use
// R4: inverted B output unconnected in normal
// R5: force bit applies mode action immediately
// R6: same-write mode bits used by force
// R7: force sets no flag, reads zero
// R8: force ignored while channel PWM on
// R9: prescaler reset self-clears, reads zero
// R10: counter write lands after sync delay
// R11: three 8-bit compares match counting up
// R12: written equality gives no match
// R13: A/B flags set after sync delay
// R14: clear-on-compare clears counter at C
// R15: compare-A request, vector three
// R16: compare-B request, vector nine
// R17: overflow request, vector four
// R18: A flag cleared on vector execution
// R19: write one clears flag after sync
// R20: reserved mask/flag bits read zero
// R21: overflow on wrap, or C in PWM
// R22: clear-on-compare sets no overflow
// R23: B flag cleared by vector or write
// R24: request is flag AND enable
// R25: writes synchronized into counter domain
`timescale 1ns/1ns
`include "tcf_map.vh"
module tcf_timer #(
   parameter PRE_W = 14
) (
   input  wire         clk,
   input  wire         arst_n,
   input  wire [7:0]   regAddr,
   input  wire [7:0]   regWdata,
   input  wire         regWr,
   input  wire         regRd,
   output reg  [7:0]   regRdata,
   input  wire         vecAck,
   input  wire [3:0]   vecNum,
   output reg          cmpAPin,
   output reg          cmpAPinOe,
   output reg          cmpAPinN,
   output reg          cmpBPin,
   output reg          cmpBPinOe,
   output reg          cmpBPinN,
   output reg          irqCmpA,
   output reg          irqCmpB,
   output reg          irqOvf
);
   function [7:0] sel8;
      input [7:0] a;
      input [7:0] ofs;
      sel8 = (a == ofs) ? 8'hff : 8'h00;
   endfunction

   reg  [7:0] gtc_r;
   reg  [7:0] tctrl_r;
   reg  [7:0] cnt_r;
   reg  [7:0] cmpA_r;
   reg  [7:0] cmpB_r;
   reg  [7:0] cmpC_r;
   reg  [7:0] mask_r;
   reg  [7:0] flags_r;
   reg  [7:0] cntWr_r;
   reg        cntWrPend_r;
   reg        cntWrHit_r;
   reg        cntTickd_r;
   reg  [`TCF_FLAG_SYNC-1:0] setA_r;
   reg  [`TCF_FLAG_SYNC-1:0] setB_r;
   reg  [`TCF_FLAG_SYNC-1:0] setO_r;
   reg  [7:0] clrPend_r;
   reg        restartC_r;
   reg        zeroByC_r;

   wire wrGtc   = regWr && (regAddr == `TCF_OFS_GTC);
   wire wrTctrl = regWr && (regAddr == `TCF_OFS_TCTRL);
   wire wrCnt   = regWr && (regAddr == `TCF_OFS_CNT);
   wire wrFlag  = regWr && (regAddr == `TCF_OFS_TFLAG);

   wire pwmB  = gtc_r[`TCF_GTC_PWMB];
   wire pwmA  = tctrl_r[`TCF_TC_PWMA];
   wire pwmOn = pwmA | pwmB;
   // same-cycle mode bits take effect for the force
   wire [1:0] modeBNow = wrGtc ? regWdata[`TCF_GTC_MODEB_HI:`TCF_GTC_MODEB_LO] : gtc_r[5:4]; // R6
   wire [1:0] modeANow = wrTctrl ? regWdata[`TCF_TC_MODEA_HI:`TCF_TC_MODEA_LO] : tctrl_r[5:4]; // R6
   wire pwmBNow = wrGtc ? regWdata[`TCF_GTC_PWMB] : pwmB;
   wire forceB = wrGtc && regWdata[`TCF_GTC_FORCEB] && !pwmBNow; // R5 R8
   wire forceA = wrGtc && regWdata[`TCF_GTC_FORCEA] && !pwmA; // R5 R8
   wire psrClr = wrGtc && regWdata[`TCF_GTC_PSR]; // R9

   wire tick;
   tcf_prescaler #(.W(PRE_W)) uPre (
      .clk    (clk),
      .arst_n (arst_n),
      .clear  (psrClr),
      .sel    (tctrl_r[3:0]),
      .tick   (tick)
   );

   // matches only on an advance of the counter, never on a write
   wire       advance = cntTickd_r && !cntWrHit_r; // R12
   wire       matchA  = advance && (cnt_r == cmpA_r); // R11
   wire       matchB  = advance && (cnt_r == cmpB_r); // R11
   wire       matchC  = advance && (cnt_r == cmpC_r); // R11
   // restart request from a C match; a zero reached this way is no overflow
   wire       restartNow = matchC && (pwmOn || tctrl_r[`TCF_TC_CLRCMP]); // R1 R14
   wire       wrap    = advance && (cnt_r == `TCF_RST_BYTE) && !zeroByC_r; // R22

   wire pinA;
   wire pinAOe;
   wire pinB;
   wire pinBOe;
   tcf_out_unit uOutA (
      .clk    (clk),
      .arst_n (arst_n),
      .fire   ((matchA && !pwmA) || forceA), // R2 R5
      .mode   (modeANow),
      .pin    (pinA),
      .pinOe  (pinAOe)
   );
   tcf_out_unit uOutB (
      .clk    (clk),
      .arst_n (arst_n),
      .fire   ((matchB && !pwmB) || forceB), // R2 R5
      .mode   (modeBNow),
      .pin    (pinB),
      .pinOe  (pinBOe)
   );

   // register writes; force and prescaler-reset bits are never stored
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gtc_r   <= `TCF_RST_BYTE;
         tctrl_r <= `TCF_RST_BYTE;
         cmpA_r  <= `TCF_RST_BYTE;
         cmpB_r  <= `TCF_RST_BYTE;
         cmpC_r  <= `TCF_CNT_TOP;
         mask_r  <= `TCF_RST_BYTE;
      end else if (regWr) begin
         if (regAddr == `TCF_OFS_GTC)
            gtc_r <= regWdata & 8'hf0; // R7 R9
         if (regAddr == `TCF_OFS_TCTRL)
            tctrl_r <= regWdata;
         if (regAddr == `TCF_OFS_CMPA)
            cmpA_r <= regWdata;
         if (regAddr == `TCF_OFS_CMPB)
            cmpB_r <= regWdata;
         if (regAddr == `TCF_OFS_CMPC)
            cmpC_r <= regWdata;
         if (regAddr == `TCF_OFS_TMASK)
            mask_r <= regWdata & `TCF_IRQ_MASK; // R20
      end
   end

   // counter: written value is staged, lands later, so writes cross cleanly
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r       <= `TCF_RST_BYTE;
         cntWr_r     <= `TCF_RST_BYTE;
         cntWrPend_r <= 1'b0;
         cntWrHit_r  <= 1'b0;
         cntTickd_r  <= 1'b0;
         restartC_r  <= 1'b0;
         zeroByC_r   <= 1'b0;
      end else begin
         cntWrPend_r <= wrCnt; // R10 R25
         if (wrCnt)
            cntWr_r <= regWdata;
         cntWrHit_r <= cntWrPend_r;
         cntTickd_r <= tick;
         // a slow prescaler keeps the restart pending until the next tick
         restartC_r <= (restartNow || restartC_r) && !tick && !cntWrPend_r;
         if (cntWrPend_r) begin
            cnt_r     <= cntWr_r; // R10
            zeroByC_r <= 1'b0;
         end else if (tick) begin
            // restart at zero on the tick right after a C match
            if (restartNow || restartC_r) begin
               cnt_r     <= `TCF_RST_BYTE; // R1 R14
               zeroByC_r <= 1'b1;
            end else begin
               cnt_r     <= cnt_r + 8'h01;
               zeroByC_r <= 1'b0;
            end
         end
      end
   end

   // flags: events delayed, set wins over clear
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         setA_r    <= {`TCF_FLAG_SYNC{1'b0}};
         setB_r    <= {`TCF_FLAG_SYNC{1'b0}};
         setO_r    <= {`TCF_FLAG_SYNC{1'b0}};
         clrPend_r <= `TCF_RST_BYTE;
         flags_r   <= `TCF_RST_BYTE;
      end else begin
         setA_r <= {setA_r[`TCF_FLAG_SYNC-2:0], matchA}; // R13
         setB_r <= {setB_r[`TCF_FLAG_SYNC-2:0], matchB}; // R13
         // overflow: wrap in normal, C match in PWM; clear-on-compare gives none
         setO_r <= {setO_r[`TCF_FLAG_SYNC-2:0], pwmOn ? matchC : wrap}; // R21 R22
         clrPend_r <= wrFlag ? (regWdata & `TCF_IRQ_MASK) : `TCF_RST_BYTE; // R19
         flags_r[`TCF_BIT_CMPA] <= setA_r[`TCF_FLAG_SYNC-1] |
            (flags_r[`TCF_BIT_CMPA] & ~clrPend_r[`TCF_BIT_CMPA] &
             ~(vecAck && vecNum == `TCF_VEC_CMPA)); // R18 R19
         flags_r[`TCF_BIT_CMPB] <= setB_r[`TCF_FLAG_SYNC-1] |
            (flags_r[`TCF_BIT_CMPB] & ~clrPend_r[`TCF_BIT_CMPB] &
             ~(vecAck && vecNum == `TCF_VEC_CMPB)); // R23
         flags_r[`TCF_BIT_OVF] <= setO_r[`TCF_FLAG_SYNC-1] |
            (flags_r[`TCF_BIT_OVF] & ~clrPend_r[`TCF_BIT_OVF] &
             ~(vecAck && vecNum == `TCF_VEC_OVF)); // R21
      end
   end

   // outputs and read data, all registered
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         regRdata  <= `TCF_RST_BYTE;
         cmpAPin   <= 1'b0;
         cmpAPinOe <= 1'b0;
         cmpAPinN  <= 1'b0;
         cmpBPin   <= 1'b0;
         cmpBPinOe <= 1'b0;
         cmpBPinN  <= 1'b0;
         irqCmpA   <= 1'b0;
         irqCmpB   <= 1'b0;
         irqOvf    <= 1'b0;
      end else begin
         regRdata <= regRd ? ((gtc_r & sel8(regAddr, `TCF_OFS_GTC)) |
                              (tctrl_r & sel8(regAddr, `TCF_OFS_TCTRL)) |
                              (cnt_r & sel8(regAddr, `TCF_OFS_CNT)) |
                              (cmpA_r & sel8(regAddr, `TCF_OFS_CMPA)) |
                              (cmpB_r & sel8(regAddr, `TCF_OFS_CMPB)) |
                              (cmpC_r & sel8(regAddr, `TCF_OFS_CMPC)) |
                              (mask_r & sel8(regAddr, `TCF_OFS_TMASK)) |
                              (flags_r & sel8(regAddr, `TCF_OFS_TFLAG))) : `TCF_RST_BYTE; // R7 R20
         // pin only reaches the pad once software sets its direction
         cmpAPin   <= pinA; // R3
         cmpAPinOe <= pinAOe;
         cmpBPin   <= pinB;
         cmpBPinOe <= pinBOe;
         // inverted outputs are left unconnected; pwm table lives elsewhere
         cmpAPinN  <= 1'b0; // R4
         cmpBPinN  <= 1'b0; // R4
         // global enable is gated by the processor
         irqCmpA <= flags_r[`TCF_BIT_CMPA] & mask_r[`TCF_BIT_CMPA]; // R15 R24
         irqCmpB <= flags_r[`TCF_BIT_CMPB] & mask_r[`TCF_BIT_CMPB]; // R16 R24
         irqOvf  <= flags_r[`TCF_BIT_OVF] & mask_r[`TCF_BIT_OVF]; // R17 R24
      end
   end
endmodule
